/* File: core/lcp_pkg.sv */
package lcp_pkg;

  localparam int OCTET_W = 8;
  localparam int MAC_W   = 48;
  localparam int PRIO_W  = 16;
  localparam int SYSID_W = 64;
  localparam int HDR_LEN = 15;
  localparam int CNT_W   = 4;

  // octet positions inside a frame, counted from the first destination octet
  localparam logic [CNT_W-1:0] DA_LAST     = 4'h5;
  localparam logic [CNT_W-1:0] SA_FIRST    = 4'h6;
  localparam logic [CNT_W-1:0] SA_LAST     = 4'hb;
  localparam logic [CNT_W-1:0] TYPE_HI     = 4'hc;
  localparam logic [CNT_W-1:0] TYPE_LO     = 4'hd;
  localparam logic [CNT_W-1:0] SUBTYPE_POS = 4'he;
  localparam logic [CNT_W-1:0] CNT_MAX     = 4'hf;

  localparam int CLK_PERIOD_PS = 10000;
  localparam int INIT_TIME_NS  = 100;
  localparam int INIT_CYCLES   = (INIT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int INIT_CNT_W    = 8;

  typedef enum logic [1:0] {
    RX_INIT = 2'b00,
    RX_IDLE = 2'b01,
    RX_HDR  = 2'b10,
    RX_BODY = 2'b11
  } lcp_rx_state_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_AGG  = 2'b01,
    TX_CTL  = 2'b10
  } lcp_tx_grant_t;

endpackage

/* File: core/lcp_ctrl_parser_mux.sv */
`timescale 1ns/1ps
module lcp_ctrl_parser_mux
  import lcp_pkg::*;
#(
  parameter int                   N_PORTS                          = 4,
  parameter int                   PORT_W                           = 2,
  parameter logic [MAC_W-1:0]     slow_protocols_multicast         = 48'h0180_c200_0002,
  parameter logic [15:0]          slow_protocols_type              = 16'h8809,
  parameter logic [OCTET_W-1:0]   aggregation_control_subtype_code = 8'h01
) (
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  input  wire logic                     reinit_req,
  input  wire logic                     port_rx_valid,
  input  wire logic [OCTET_W-1:0]       port_rx_data,
  input  wire logic                     port_rx_sof,
  input  wire logic                     port_rx_eof,
  input  wire logic [PORT_W-1:0]        port_rx_port,
  output logic                          ctl_rx_valid,
  output logic [OCTET_W-1:0]            ctl_rx_data,
  output logic                          ctl_rx_sof,
  output logic                          ctl_rx_eof,
  output logic [PORT_W-1:0]             ctl_rx_port,
  output logic                          parser_to_aggregator_valid,
  output logic [OCTET_W-1:0]            parser_to_aggregator_data,
  output logic                          parser_to_aggregator_sof,
  output logic                          parser_to_aggregator_eof,
  output logic [PORT_W-1:0]             parser_to_aggregator_port,
  input  wire logic                     agg_tx_valid,
  input  wire logic [OCTET_W-1:0]       agg_tx_data,
  input  wire logic                     agg_tx_sof,
  input  wire logic                     agg_tx_eof,
  input  wire logic [PORT_W-1:0]        agg_tx_port,
  input  wire logic                     agg_tx_sa_given,
  output logic                          agg_tx_ready,
  input  wire logic                     ctl_tx_valid,
  input  wire logic [OCTET_W-1:0]       ctl_tx_data,
  input  wire logic                     ctl_tx_sof,
  input  wire logic                     ctl_tx_eof,
  input  wire logic [PORT_W-1:0]        ctl_tx_port,
  output logic                          ctl_tx_ready,
  output logic                          tx_valid,
  output logic [OCTET_W-1:0]            tx_data,
  output logic                          tx_sof,
  output logic                          tx_eof,
  output logic [PORT_W-1:0]             tx_port,
  input  wire logic [MAC_W-1:0]         agg_mac,
  input  wire logic [N_PORTS*MAC_W-1:0] port_macs,
  input  wire logic [PRIO_W-1:0]        sys_priority,
  input  wire logic [MAC_W-1:0]         sys_mac,
  output logic [SYSID_W-1:0]            sys_id,
  output logic                          init_active
);

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [OCTET_W-1:0] mac_octet(input logic [MAC_W-1:0] mac,
                                                   input logic [CNT_W-1:0] k);
    logic [OCTET_W-1:0] r;
    r = 8'h00;
    for (int i = 0; i < MAC_W / OCTET_W; i++) begin
      if (k == CNT_W'(i)) begin
        r = mac[MAC_W-1-OCTET_W*i -: OCTET_W];
      end
    end
    return r;
  endfunction

  function automatic logic [OCTET_W-1:0] bitrev8(input logic [OCTET_W-1:0] b);
    logic [OCTET_W-1:0] r;
    r = 8'h00;
    for (int i = 0; i < OCTET_W; i++) begin
      r[i] = b[OCTET_W-1-i];
    end
    return r;
  endfunction

  // ************************************************************
  // initialisation flag
  // ************************************************************
  logic [INIT_CNT_W-1:0] init_cnt_reg;
  logic                  init_active_reg;
  wire                   init_done = (init_cnt_reg == INIT_CNT_W'(INIT_CYCLES - 1));

  always_ff @(posedge clk_sys) begin
    if (rst || reinit_req) begin
      init_cnt_reg    <= '0;
      init_active_reg <= 1'b1;
    end else if (init_active_reg) begin
      init_cnt_reg    <= init_cnt_reg + INIT_CNT_W'(1);
      init_active_reg <= !init_done;
    end
  end

  // ************************************************************
  // receive classifier
  // ************************************************************
  lcp_rx_state_t    rx_state_reg;
  lcp_rx_state_t    rx_state_next;
  logic [CNT_W-1:0] rx_cnt_reg;
  logic             match_reg;
  logic             route_ctl_reg;

  wire              rx_run   = !init_active_reg && (rx_state_reg != RX_INIT);
  wire              rx_start = rx_run && port_rx_valid && port_rx_sof;
  wire              rx_in    = rx_start
                               || (rx_run && port_rx_valid && rx_state_reg != RX_IDLE);
  wire [CNT_W-1:0]  rx_idx   = rx_start ? '0 : rx_cnt_reg;
  wire              in_da    = (rx_idx <= DA_LAST);
  wire [OCTET_W-1:0] da_exp  = mac_octet(slow_protocols_multicast, rx_idx);
  // subtype is the octet that directly follows the length/type field
  wire              hdr_ok   = in_da ? (port_rx_data == da_exp) :
                               (rx_idx == TYPE_HI) ? (port_rx_data == slow_protocols_type[15:8]) :
                               (rx_idx == TYPE_LO) ? (port_rx_data == slow_protocols_type[7:0]) :
                               (rx_idx == SUBTYPE_POS) ?
                                 (port_rx_data == aggregation_control_subtype_code) : 1'b1;
  wire              decide   = rx_in && (rx_idx == SUBTYPE_POS);

  always_comb begin
    rx_state_next = rx_state_reg;
    case (rx_state_reg)
      RX_INIT: rx_state_next = RX_IDLE;
      RX_IDLE: if (rx_start) rx_state_next = RX_HDR;
      RX_HDR:  if (decide) rx_state_next = RX_BODY;
      RX_BODY: if (port_rx_valid && port_rx_eof) rx_state_next = RX_IDLE;
      default: rx_state_next = RX_INIT;
    endcase
    if (rx_in && port_rx_eof && rx_state_reg != RX_BODY) begin
      rx_state_next = RX_IDLE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || init_active_reg) begin
      rx_state_reg  <= RX_INIT;
      rx_cnt_reg    <= '0;
      match_reg     <= 1'b0;
      route_ctl_reg <= 1'b0;
    end else begin
      rx_state_reg <= rx_state_next;
      if (rx_in) begin
        rx_cnt_reg <= (rx_idx == CNT_MAX) ? CNT_MAX : rx_idx + CNT_W'(1);
        match_reg  <= (rx_start || match_reg) && hdr_ok;
      end
      if (decide) begin
        route_ctl_reg <= match_reg && hdr_ok;
      end
    end
  end

  // header hold line: the verdict is known when the first octet leaves it
  logic [OCTET_W-1:0] pd_reg [HDR_LEN];
  logic [PORT_W-1:0]  pp_reg [HDR_LEN];
  logic               pv_reg [HDR_LEN];
  logic               ps_reg [HDR_LEN];
  logic               pe_reg [HDR_LEN];

  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < HDR_LEN; i++) begin
      pd_reg[i] <= (i == 0) ? port_rx_data : pd_reg[(i == 0) ? 0 : i - 1];
      pp_reg[i] <= (i == 0) ? port_rx_port : pp_reg[(i == 0) ? 0 : i - 1];
      ps_reg[i] <= (i == 0) ? port_rx_sof  : ps_reg[(i == 0) ? 0 : i - 1];
      pe_reg[i] <= (i == 0) ? port_rx_eof  : pe_reg[(i == 0) ? 0 : i - 1];
      if (rst || init_active_reg) begin
        pv_reg[i] <= 1'b0;
      end else begin
        pv_reg[i] <= (i == 0) ? rx_in : pv_reg[(i == 0) ? 0 : i - 1];
      end
    end
  end

  wire out_v = pv_reg[HDR_LEN-1];

  always_ff @(posedge clk_sys) begin
    ctl_rx_data               <= pd_reg[HDR_LEN-1];
    ctl_rx_sof                <= ps_reg[HDR_LEN-1];
    ctl_rx_eof                <= pe_reg[HDR_LEN-1];
    ctl_rx_port               <= pp_reg[HDR_LEN-1];
    parser_to_aggregator_data <= pd_reg[HDR_LEN-1];
    parser_to_aggregator_sof  <= ps_reg[HDR_LEN-1];
    parser_to_aggregator_eof  <= pe_reg[HDR_LEN-1];
    parser_to_aggregator_port <= pp_reg[HDR_LEN-1];
    if (rst || init_active_reg) begin
      ctl_rx_valid               <= 1'b0;
      parser_to_aggregator_valid <= 1'b0;
    end else begin
      ctl_rx_valid               <= out_v && route_ctl_reg;
      parser_to_aggregator_valid <= out_v && !route_ctl_reg;
    end
  end

  // ************************************************************
  // transmit multiplexer
  // ************************************************************
  lcp_tx_grant_t    grant_reg;
  lcp_tx_grant_t    grant_next;
  logic [CNT_W-1:0] tx_cnt_reg;
  logic             sa_fill_reg;

  wire              sel_ctl  = (grant_reg == TX_CTL);
  wire              src_v    = sel_ctl ? ctl_tx_valid : agg_tx_valid;
  wire [OCTET_W-1:0] src_d   = sel_ctl ? ctl_tx_data  : agg_tx_data;
  wire              src_s    = sel_ctl ? ctl_tx_sof   : agg_tx_sof;
  wire              src_e    = sel_ctl ? ctl_tx_eof   : agg_tx_eof;
  wire [PORT_W-1:0] src_p    = sel_ctl ? ctl_tx_port  : agg_tx_port;
  wire              xfer     = (grant_reg != TX_IDLE) && src_v && (agg_tx_ready || ctl_tx_ready);
  wire [CNT_W-1:0]  tx_idx   = src_s ? '0 : tx_cnt_reg;
  wire              in_sa    = (tx_idx >= SA_FIRST) && (tx_idx <= SA_LAST);
  wire [CNT_W-1:0]  sa_k     = tx_idx - SA_FIRST;
  // control frames always leave with the egress port address; client frames get agg_mac unless agg_tx_sa_given is set
  wire              fill_now = sel_ctl || (src_s ? !agg_tx_sa_given : sa_fill_reg);
  wire [MAC_W-1:0]  egress_mac = port_macs[32'(src_p) * MAC_W +: MAC_W];
  wire [OCTET_W-1:0] sa_oct  = sel_ctl ? mac_octet(egress_mac, sa_k)
                                       : mac_octet(agg_mac, sa_k);
  wire [OCTET_W-1:0] tx_d    = (in_sa && fill_now) ? sa_oct : src_d;

  always_comb begin
    grant_next = grant_reg;
    case (grant_reg)
      TX_IDLE: begin
        // control traffic wins a tie; it is rare and must not starve
        if (ctl_tx_valid && ctl_tx_sof) begin
          grant_next = TX_CTL;
        end else if (agg_tx_valid && agg_tx_sof) begin
          grant_next = TX_AGG;
        end
      end
      TX_AGG, TX_CTL: if (xfer && src_e) grant_next = TX_IDLE;
      default: grant_next = TX_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst || init_active_reg) begin
      grant_reg    <= TX_IDLE;
      tx_cnt_reg   <= '0;
      sa_fill_reg  <= 1'b0;
      agg_tx_ready <= 1'b0;
      ctl_tx_ready <= 1'b0;
      tx_valid     <= 1'b0;
    end else begin
      grant_reg    <= grant_next;
      agg_tx_ready <= (grant_next == TX_AGG);
      ctl_tx_ready <= (grant_next == TX_CTL);
      tx_valid     <= xfer;
      if (xfer) begin
        tx_cnt_reg <= (tx_idx == CNT_MAX) ? CNT_MAX : tx_idx + CNT_W'(1);
        if (src_s) begin
          sa_fill_reg <= !agg_tx_sa_given;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    tx_data <= tx_d;
    tx_sof  <= src_s;
    tx_eof  <= src_e;
    tx_port <= src_p;
  end

  // ************************************************************
  // system identifier
  // ************************************************************
  logic [SYSID_W-1:0] sys_id_next;

  always_comb begin
    sys_id_next = '0;
    sys_id_next[SYSID_W-1 -: PRIO_W] = sys_priority;
    for (int k = 0; k < MAC_W / OCTET_W; k++) begin
      sys_id_next[MAC_W-1-OCTET_W*k -: OCTET_W] = bitrev8(mac_octet(sys_mac, CNT_W'(k)));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sys_id      <= '0;
      init_active <= 1'b1;
    end else begin
      sys_id      <= sys_id_next;
      init_active <= init_active_reg;
    end
  end

endmodule // lcp_ctrl_parser_mux

/* File: bench/lcp_chk.sv */
`timescale 1ns/1ps
module lcp_chk
  import lcp_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        reinit_req,
  input wire logic        port_rx_valid,
  input wire logic        ctl_rx_valid,
  input wire logic        parser_to_aggregator_valid,
  input wire logic        agg_tx_valid,
  input wire logic        agg_tx_ready,
  input wire logic        ctl_tx_valid,
  input wire logic        ctl_tx_ready,
  input wire logic        tx_valid,
  input wire logic [15:0] sys_priority,
  input wire logic [47:0] sys_mac,
  input wire logic [63:0] sys_id,
  input wire logic        init_active
);
  logic [63:0] id_exp;
  // bit b of an octet lands at 7-b: first sent bit becomes the lsb
  always_comb begin
    id_exp[63:48] = sys_priority;
    for (int b = 0; b < 48; b++) id_exp[b ^ 7] = sys_mac[b];
  end
  default clocking dcb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // ****************************************
  // assertions
  // ****************************************
  a_ctl_lat: assert property (ctl_rx_valid |-> $past(port_rx_valid, 16))
    else $error("control octet without input octet");
  a_agg_lat: assert property (parser_to_aggregator_valid |-> $past(port_rx_valid, 16))
    else $error("aggregator octet without input octet");
  a_rx_excl: assert property (!(ctl_rx_valid && parser_to_aggregator_valid))
    else $error("octet sent to both outputs");
  a_init_quiet: assert property (init_active |->
    !(tx_valid || agg_tx_ready || ctl_tx_ready || ctl_rx_valid || parser_to_aggregator_valid))
    else $error("traffic during initialisation");
  a_init_rise: assert property (reinit_req |-> ##[1:2] init_active)
    else $error("init flag not raised");
  a_init_end: assert property ($rose(init_active) |->
    init_active[*8] ##[1:6] !init_active)
    else $error("init flag length wrong");
  a_sys_ident: assert property (1'b1 |=> sys_id == $past(id_exp))
    else $error("system id wrong");
  a_tx_follow: assert property (tx_valid |->
    $past(agg_tx_valid && agg_tx_ready || ctl_tx_valid && ctl_tx_ready))
    else $error("tx octet not accepted before");
  a_one_grant: assert property (!(agg_tx_ready && ctl_tx_ready))
    else $error("both sources granted");
endmodule // lcp_chk

bind lcp_ctrl_parser_mux lcp_chk u_chk (.*);

/* File: bench/lcp_mac_model.sv */
`timescale 1ns/1ps
module lcp_mac_model (
  input  wire logic       clk_sys,
  output logic            port_rx_valid,
  output logic [7:0]      port_rx_data,
  output logic            port_rx_sof,
  output logic            port_rx_eof,
  output logic [1:0]      port_rx_port,
  output logic            agg_tx_valid,
  output logic            ctl_tx_valid,
  output logic [7:0]      mtx_data,
  output logic            mtx_sof,
  output logic            mtx_eof,
  output logic [1:0]      mtx_port,
  output logic            agg_tx_sa_given,
  input  wire logic       agg_tx_ready,
  input  wire logic       ctl_tx_ready,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic [1:0] tx_port,
  input  wire logic       tx_sof,
  input  wire logic       tx_eof
);
  logic [11:0] txq[$];
  logic       tx_req;
  logic       sel_ctl;
  initial begin
    {port_rx_valid, port_rx_data, port_rx_sof, port_rx_eof, port_rx_port, tx_req, sel_ctl,
     mtx_data, mtx_sof, mtx_eof, mtx_port, agg_tx_sa_given} = '0;
  end
  assign agg_tx_valid = tx_req & ~sel_ctl;
  assign ctl_tx_valid = tx_req & sel_ctl;
  // ****************************************
  // mac side: rx source and tx sink
  // ****************************************
  always @(posedge clk_sys) if (tx_valid === 1'b1) txq.push_back({tx_sof, tx_eof, tx_port, tx_data});
  // valid stays up so frames can follow back to back; rx_stop drops it
  task automatic rx_send(input logic [127:0] f, input logic [1:0] p);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_sys);
      port_rx_valid <= 1'b1;
      port_rx_data  <= f[127-8*i -: 8];
      port_rx_sof   <= (i == 0);
      port_rx_eof   <= (i == 15);
      port_rx_port  <= p;
    end
  endtask
  task automatic rx_stop();
    @(posedge clk_sys);
    port_rx_valid <= 1'b0;
    port_rx_data  <= ~port_rx_data;
  endtask
  // ****************************************
  // client side: tx source, held until ready
  // ****************************************
  task automatic tx_send(input logic c, input logic [1:0] p, input logic sa,
                         input logic [127:0] f);
    int i = 0;
    @(posedge clk_sys);
    sel_ctl         <= c;
    tx_req          <= 1'b1;
    mtx_data        <= f[127:120];
    mtx_sof         <= 1'b1;
    mtx_eof         <= 1'b0;
    mtx_port        <= p;
    agg_tx_sa_given <= sa;
    while (i < 16) begin
      @(posedge clk_sys);
      if (c ? ctl_tx_ready : agg_tx_ready) begin
        i++;
        if (i < 16) begin
          mtx_data <= f[127-8*i -: 8];
          mtx_sof  <= 1'b0;
          mtx_eof  <= (i == 15);
        end
      end
    end
    tx_req   <= 1'b0;
    mtx_data <= ~mtx_data;
  endtask
endmodule // lcp_mac_model

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import lcp_pkg::*;
  localparam logic [47:0]  MC  = 48'h0180_c200_0002;
  localparam logic [47:0]  SAX = 48'h1122_3344_5566;
  localparam logic [127:0] TXF = {48'h0a0b_0c0d_0e0f, SAX, 32'h8809_0155, 32'hdead_beef};
  logic               clk_sys = 1'b0;
  logic               rst = 1'b1;
  logic               reinit_req = 1'b0;
  logic [47:0]        agg_mac = 48'h0200_0000_00a1;
  logic [191:0]       port_macs = {48'h0200_0000_0b03, 48'h0200_0000_0b02,
                                   48'h0200_0000_0b01, 48'h0200_0000_0b00};
  logic [15:0]        sys_priority = 16'h8001;
  logic [47:0]        sys_mac = 48'h01e2_3c45_6a87;
  logic               port_rx_valid, port_rx_sof, port_rx_eof, agg_tx_valid, ctl_tx_valid;
  logic               mtx_sof, mtx_eof, agg_tx_sa_given, agg_tx_ready, ctl_tx_ready;
  logic               ctl_rx_valid, parser_to_aggregator_valid, tx_valid, init_active;
  logic               ctl_rx_sof, ctl_rx_eof, p2a_sof, p2a_eof, tx_sof, tx_eof;
  logic [1:0]         ctl_rx_port, p2a_port;
  logic [7:0]         port_rx_data, mtx_data, ctl_rx_data, p2a_data, tx_data;
  logic [1:0]         port_rx_port, mtx_port, tx_port;
  logic [63:0]        sys_id;
  logic [11:0]        cq[$], aq[$];
  int                 fail_count = 0, checks_done = 0, cyc = 0;

  lcp_ctrl_parser_mux u_dut (
    .clk_sys(clk_sys), .rst(rst), .reinit_req(reinit_req),
    .port_rx_valid(port_rx_valid), .port_rx_data(port_rx_data), .port_rx_sof(port_rx_sof),
    .port_rx_eof(port_rx_eof), .port_rx_port(port_rx_port), .ctl_rx_valid(ctl_rx_valid),
    .ctl_rx_data(ctl_rx_data), .ctl_rx_sof(ctl_rx_sof), .ctl_rx_eof(ctl_rx_eof),
    .ctl_rx_port(ctl_rx_port), .parser_to_aggregator_valid(parser_to_aggregator_valid),
    .parser_to_aggregator_data(p2a_data), .parser_to_aggregator_sof(p2a_sof),
    .parser_to_aggregator_eof(p2a_eof), .parser_to_aggregator_port(p2a_port),
    .agg_tx_valid(agg_tx_valid), .agg_tx_data(mtx_data), .agg_tx_sof(mtx_sof),
    .agg_tx_eof(mtx_eof), .agg_tx_port(mtx_port), .agg_tx_sa_given(agg_tx_sa_given),
    .agg_tx_ready(agg_tx_ready), .ctl_tx_valid(ctl_tx_valid), .ctl_tx_data(mtx_data),
    .ctl_tx_sof(mtx_sof), .ctl_tx_eof(mtx_eof), .ctl_tx_port(mtx_port),
    .ctl_tx_ready(ctl_tx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_sof(tx_sof),
    .tx_eof(tx_eof), .tx_port(tx_port), .agg_mac(agg_mac), .port_macs(port_macs),
    .sys_priority(sys_priority), .sys_mac(sys_mac), .sys_id(sys_id),
    .init_active(init_active));
  lcp_mac_model u_mac (.*);

  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (ctl_rx_valid === 1'b1) cq.push_back({ctl_rx_sof, ctl_rx_eof, ctl_rx_port, ctl_rx_data});
    if (parser_to_aggregator_valid === 1'b1) aq.push_back({p2a_sof, p2a_eof, p2a_port, p2a_data});
    if (cyc == 2000) begin
      fail_count++;
      finish_test();
    end
  end
  // ****************************************
  // checking helpers
  // ****************************************
  task automatic chk(input string n, input logic [127:0] s, input logic [127:0] e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wait_init();
    for (int i = 0; i < 40 && init_active !== 1'b0; i++) @(posedge clk_sys);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_sysid();
    logic [63:0] e;
    e[63:48] = sys_priority;
    for (int k = 0; k < 6; k++) begin
      for (int j = 0; j < 8; j++) e[40-8*k+j] = sys_mac[47-8*k-j];
    end
    chk("sys_id", 128'(sys_id), 128'(e));
  endtask
  task automatic t_reinit();
    @(posedge clk_sys);
    reinit_req <= 1'b1;
    @(posedge clk_sys);
    reinit_req <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk("init_on", 128'(init_active), 128'd1);
    wait_init();
    chk("init_off", 128'(init_active), 128'd0);
  endtask
  // one control frame then three near misses, back to back
  task automatic t_rx();
    logic [127:0] f[4];
    logic [127:0] v;
    logic [11:0]  o;
    f[0] = {MC, SAX, 32'h8809_015a};
    f[1] = {MC, SAX, 32'h8809_025a};
    f[2] = {MC, SAX, 32'h8808_015a};
    f[3] = {MC ^ 48'h1, SAX, 32'h8809_015a};
    for (int i = 0; i < 4; i++) u_mac.rx_send(f[i], 2'(i));
    u_mac.rx_stop();
    repeat (20) @(posedge clk_sys);
    chk("ctl_len", 128'(cq.size()), 128'd16);
    chk("agg_len", 128'(aq.size()), 128'd48);
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 16; i++) begin
        o = (k == 0) ? cq.pop_front() : aq.pop_front();
        v = {v[119:0], o[7:0]};
        chk("rx_mark", 128'(o[11:8]), 128'({i == 0, i == 15, 2'(k)}));
      end
      chk("rx_frame", v, f[k]);
    end
  endtask
  task automatic t_tx(input logic c, input logic [1:0] p, input logic sa,
                      input logic [127:0] e);
    logic [127:0] v;
    u_mac.tx_send(c, p, sa, TXF);
    repeat (3) @(posedge clk_sys);
    chk("tx_len", 128'(u_mac.txq.size()), 128'd16);
    for (int i = 0; i < 16; i++) begin
      v = {v[119:0], u_mac.txq[i][7:0]};
      chk("tx_mark", 128'(u_mac.txq[i][11:8]), 128'({i == 0, i == 15, p}));
    end
    chk("tx_frame", v, e);
    u_mac.txq.delete();
  endtask

  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    wait_init();
    t_sysid();
    t_reinit();
    t_rx();
    t_tx(1'b0, 2'd3, 1'b0, {TXF[127:80], agg_mac, TXF[31:0]});
    t_tx(1'b0, 2'd0, 1'b1, TXF);
    t_tx(1'b1, 2'd2, 1'b1, {TXF[127:80], port_macs[143:96], TXF[31:0]});
    finish_test();
  end
endmodule // tb_top
